// ===== bench/exrn_pipe_model.sv
// Retirement pipeline and external interrupt sources that drive the unit.
`timescale 1ns/100ps
module exrn_pipe_model (
  // Clock
  input wire logic clk_sys
);
  integer pseed = 13;
  logic retire_valid = 1'b0, retire_rep_iter = 1'b0, retire_interrupt_return_instruction = 1'b0;
  logic retire_int3 = 1'b0, retire_into = 1'b0, retire_intn = 1'b0, retire_exc = 1'b0;
  logic retire_partial_state = 1'b0, overflow_flag = 1'b0, processor_flags_if = 1'b0;
  logic mchk_err = 1'b0, nmi_pin = 1'b0, bus_msg_valid = 1'b0, maskable_interrupt_pin = 1'b0;
  logic [2:0] bus_msg_mode = 3'h0;
  logic [7:0] retire_intn_vec = 8'h00, retire_exc_vec = 8'h00, maskable_vec = 8'h00;
  logic [31:0] retire_ip = 32'h0, retire_next_ip = 32'h0;
  logic [31:0] retire_exc_err = 32'h0, mchk_code = 32'h0;

  // Kind bits are interrupt_return_instruction, repeat, partial, exception, intn, into, int3 from the top.
  task automatic retire(input logic [6:0] k, input logic [7:0] v, input logic [31:0] ip, nip);
    @(posedge clk_sys);
    #1;
    {retire_interrupt_return_instruction, retire_rep_iter, retire_partial_state, retire_exc, retire_intn} = k[6:2];
    {retire_into, retire_int3} = k[1:0];
    retire_valid = 1'b1;
    retire_intn_vec = v;
    retire_exc_vec = v;
    retire_exc_err = {4{v}};
    retire_ip = ip;
    retire_next_ip = nip;
    @(posedge clk_sys);
    #1;
    retire_valid = 1'b0;
    {retire_interrupt_return_instruction, retire_rep_iter, retire_partial_state, retire_exc, retire_intn} = 5'h00;
    {retire_into, retire_int3} = 2'h0;
    // Stale fields are scrambled so a design that ignores the valid strobe is caught.
    retire_intn_vec = ~v;
    retire_exc_vec = ~v;
    retire_exc_err = ~{4{v}};
    retire_ip = ~ip;
    retire_next_ip = $random(pseed);
  endtask

  task automatic levels(input logic nmi, ifl, ovf, mpin, input logic [7:0] mvec);
    @(posedge clk_sys);
    #1;
    nmi_pin = nmi;
    processor_flags_if = ifl;
    overflow_flag = ovf;
    maskable_interrupt_pin = mpin;
    maskable_vec = mvec;
  endtask

  task automatic pulse_bus(input logic [2:0] mode);
    @(posedge clk_sys);
    #1;
    bus_msg_valid = 1'b1;
    bus_msg_mode = mode;
    @(posedge clk_sys);
    #1;
    bus_msg_valid = 1'b0;
    bus_msg_mode = ~mode;
  endtask

  task automatic pulse_mchk(input logic [31:0] code);
    @(posedge clk_sys);
    #1;
    mchk_err = 1'b1;
    mchk_code = code;
    @(posedge clk_sys);
    #1;
    mchk_err = 1'b0;
    mchk_code = ~code;
  endtask
endmodule

// ===== bench/exrn_unit_bench.sv
// Self-checking bench for the exception and nonmaskable-interrupt acceptance unit.
`timescale 1ns/100ps
module exrn_unit_bench;
  import exrn_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  integer seed = 13;
  integer errors = 0;
  integer n_compared = 0;
  logic disp_valid, disp_push_err, disp_rollback, disp_restartable, disp_src_maskable_interrupt_pin;
  logic maskable_ack, nmi_block;
  logic [7:0] disp_vec;
  exrn_class_e disp_class;
  logic [31:0] disp_ret_ip, disp_err;
  logic [7:0] exv [13] = '{8'h00, 8'h05, 8'h06, 8'h07, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e,
                           8'h10, 8'h11, 8'h13, 8'h01};

  initial forever #2.5 clk_sys = ~clk_sys;

  exrn_pipe_model pm (.clk_sys(clk_sys));

  exrn_unit uut (
    .clk_sys(clk_sys), .sys_rst(sys_rst),
    .retire_valid(pm.retire_valid), .retire_ip(pm.retire_ip),
    .retire_next_ip(pm.retire_next_ip), .retire_rep_iter(pm.retire_rep_iter),
    .retire_interrupt_return_instruction(pm.retire_interrupt_return_instruction), .retire_int3(pm.retire_int3),
    .retire_into(pm.retire_into), .retire_intn(pm.retire_intn),
    .retire_intn_vec(pm.retire_intn_vec), .retire_exc(pm.retire_exc),
    .retire_exc_vec(pm.retire_exc_vec), .retire_exc_err(pm.retire_exc_err),
    .retire_partial_state(pm.retire_partial_state), .overflow_flag(pm.overflow_flag),
    .processor_flags_if(pm.processor_flags_if), .mchk_err(pm.mchk_err),
    .mchk_code(pm.mchk_code), .nmi_pin(pm.nmi_pin), .bus_msg_valid(pm.bus_msg_valid),
    .bus_msg_mode(pm.bus_msg_mode), .maskable_interrupt_pin(pm.maskable_interrupt_pin),
    .maskable_vec(pm.maskable_vec), .disp_valid(disp_valid), .disp_vec(disp_vec),
    .disp_class(disp_class), .disp_ret_ip(disp_ret_ip), .disp_push_err(disp_push_err),
    .disp_err(disp_err), .disp_rollback(disp_rollback), .disp_restartable(disp_restartable),
    .disp_src_maskable_interrupt_pin(disp_src_maskable_interrupt_pin), .maskable_ack(maskable_ack), .nmi_block(nmi_block)
  );

  function automatic logic exc_err(input logic [7:0] v);
    return v == 8'h11 || (v >= 8'h0a && v <= 8'h0e);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk_disp(input logic [7:0] v, input logic [31:0] c, ip, input logic pe, si);
    check(32'(disp_valid), 32'h1);
    check(32'(disp_vec), 32'(v));
    check(32'(disp_class), c);
    check(disp_ret_ip, ip);
    check(32'(disp_push_err), 32'(pe));
    check(32'(disp_src_maskable_interrupt_pin), 32'(si));
  endtask

  task automatic give_verdict;
    $display("compared %0d mismatched %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    logic [31:0] ip, nip;
    logic [7:0] v;
    repeat (4) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    // A breakpoint on a jump returns to the jump target.
    pm.retire(7'h01, 8'h00, 32'h0000_1000, 32'h0000_8000);
    chk_disp(EXRN_VEC_BP, 32'(EXRN_CLS_TRAP), 32'h0000_8000, 1'b0, 1'b0);
    pm.retire(7'h02, 8'h00, 32'h0000_2000, 32'h0000_2001);
    check(32'(disp_valid), 32'h0);
    pm.levels(1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
    pm.retire(7'h02, 8'h00, 32'h0000_2000, 32'h0000_2001);
    chk_disp(EXRN_VEC_OVF, 32'(EXRN_CLS_TRAP), 32'h0000_2001, 1'b0, 1'b0);
    $display("software exception test done");
    for (int n = 0; n < 40; n++)
    begin
      ip = $random(seed);
      nip = ip + 32'(($random(seed) & 15) + 1);
      if ($random(seed) & 1)
      begin
        v = 8'($random(seed));
        pm.retire(7'h04, v, ip, nip);
        chk_disp(v, 32'(EXRN_CLS_MASKABLE_INTERRUPT_PIN), nip, 1'b0, 1'b1);
        check(32'(nmi_block), 32'h0);
      end
      else
      begin
        v = exv[$unsigned($random(seed)) % 12];
        pm.retire(7'h08, v, ip, nip);
        chk_disp(v, 32'(EXRN_CLS_FAULT), ip, exc_err(v), 1'b0);
        check(32'(disp_rollback), 32'h1);
        check(32'(disp_restartable), 32'h1);
        if (exc_err(v))
          check(disp_err, {4{v}});
      end
    end
    pm.retire(7'h18, 8'h0c, 32'h0000_3000, 32'h0000_3001);
    chk_disp(8'h0c, 32'(EXRN_CLS_FAULT), 32'h0000_3000, 1'b1, 1'b0);
    check(32'(disp_restartable), 32'h0);
    pm.retire(7'h08, EXRN_VEC_DF, 32'h0000_4000, 32'h0000_4001);
    check(32'(disp_class), 32'(EXRN_CLS_ABORT));
    check(32'(disp_restartable), 32'h0);
    pm.retire(7'h08, 8'h01, 32'h0000_4100, 32'h0000_4108);
    chk_disp(8'h01, 32'(EXRN_CLS_TRAP), 32'h0000_4108, 1'b0, 1'b0);
    $display("random exception test done");
    // A pending maskable request waits for a retired boundary, then a repeat iteration.
    pm.levels(1'b0, 1'b1, 1'b0, 1'b1, 8'h41);
    repeat (5)
    begin
      @(posedge clk_sys);
      #1;
      check(32'(disp_valid), 32'h0);
    end
    pm.retire(7'h20, 8'h00, 32'h0000_5000, 32'h0000_5000);
    chk_disp(8'h41, 32'(EXRN_CLS_MASKABLE_INTERRUPT_PIN), 32'h0000_5000, 1'b0, 1'b1);
    check(32'(maskable_ack), 32'h1);
    pm.levels(1'b0, 1'b1, 1'b0, 1'b1, EXRN_VEC_NMI);
    pm.retire(7'h00, 8'h00, 32'h0000_5100, 32'h0000_5104);
    chk_disp(EXRN_VEC_NMI, 32'(EXRN_CLS_MASKABLE_INTERRUPT_PIN), 32'h0000_5104, 1'b0, 1'b1);
    check(32'(maskable_ack), 32'h1);
    check(32'(nmi_block), 32'h0);
    $display("maskable test done");
    // The pin event arrives with interrupts disabled; a bus message then waits blocked.
    pm.levels(1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
    pm.retire(7'h00, 8'h00, 32'h0000_6000, 32'h0000_6004);
    chk_disp(EXRN_VEC_NMI, 32'(EXRN_CLS_MASKABLE_INTERRUPT_PIN), 32'h0000_6004, 1'b0, 1'b1);
    check(32'(nmi_block), 32'h1);
    pm.pulse_bus(EXRN_MODE_NMI);
    pm.levels(1'b0, 1'b1, 1'b0, 1'b1, 8'h41);
    pm.retire(7'h00, 8'h00, 32'h0000_6004, 32'h0000_6008);
    check(32'(disp_valid), 32'h0);
    pm.levels(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
    pm.retire(7'h40, 8'h00, 32'h0000_6100, 32'h0000_6200);
    check(32'(nmi_block), 32'h0);
    pm.retire(7'h00, 8'h00, 32'h0000_6200, 32'h0000_6204);
    chk_disp(EXRN_VEC_NMI, 32'(EXRN_CLS_MASKABLE_INTERRUPT_PIN), 32'h0000_6204, 1'b0, 1'b1);
    check(32'(nmi_block), 32'h1);
    pm.retire(7'h40, 8'h00, 32'h0000_6300, 32'h0000_6400);
    check(32'(nmi_block), 32'h0);
    pm.pulse_bus(3'h0);
    pm.retire(7'h00, 8'h00, 32'h0000_6400, 32'h0000_6404);
    check(32'(disp_valid), 32'h0);
    $display("nonmaskable test done");
    pm.pulse_mchk(32'h5a5a_0012);
    @(posedge clk_sys);
    #1;
    check(32'(disp_valid), 32'h1);
    check(32'(disp_vec), 32'(EXRN_VEC_MC));
    check(32'(disp_class), 32'(EXRN_CLS_ABORT));
    check(32'(disp_push_err), 32'h1);
    check(disp_err, 32'h5a5a_0012);
    $display("machine check test done");
    give_verdict();
  end
endmodule

// ===== common/exrn_pkg.sv
// Shared constants and types for the exception and nonmaskable-interrupt acceptance unit.
package exrn_pkg;
  localparam int EXRN_VEC_W = 8;
  localparam int EXRN_IP_W = 32;
  localparam int EXRN_ERR_W = 32;
  localparam logic [7:0] EXRN_VEC_NMI = 8'h02;
  localparam logic [7:0] EXRN_VEC_BP = 8'h03;
  localparam logic [7:0] EXRN_VEC_OVF = 8'h04;
  localparam logic [7:0] EXRN_VEC_DF = 8'h08;
  localparam logic [7:0] EXRN_VEC_MC = 8'h12;
  localparam logic [2:0] EXRN_MODE_NMI = 3'h4;
  localparam logic [31:0] EXRN_ERR_ZERO = 32'h0000_0000;
  localparam logic [31:0] EXRN_IP_RST = 32'h0000_0000;
  localparam logic [7:0] EXRN_VEC_RST = 8'h00;

  typedef enum logic [1:0] {
    EXRN_CLS_FAULT,
    EXRN_CLS_TRAP,
    EXRN_CLS_ABORT,
    EXRN_CLS_MASKABLE_INTERRUPT_PIN
  } exrn_class_e;

  typedef enum logic [1:0] {
    EXRN_SRC_NONE,
    EXRN_SRC_EXC,
    EXRN_SRC_MASKABLE_INTERRUPT_PIN
  } exrn_src_e;
endpackage

// ===== verilog/exrn_class_table.sv
// Fixed per-vector class table with error-code push flags.
`timescale 1ns/100ps
module exrn_class_table
  import exrn_pkg::*;
(
  // Lookup
  input wire logic [exrn_pkg::EXRN_VEC_W-1:0] vec,
  output exrn_pkg::exrn_class_e cls,
  output logic has_err
);
  always_comb
  begin
    cls = EXRN_CLS_MASKABLE_INTERRUPT_PIN;
    has_err = 1'b0;
    case (vec)
      8'h00, 8'h05, 8'h06, 8'h07, 8'h09, 8'h10, 8'h13: cls = EXRN_CLS_FAULT;
      8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h11:
      begin
        cls = EXRN_CLS_FAULT;
        has_err = 1'b1;
      end
      8'h01, 8'h03, 8'h04: cls = EXRN_CLS_TRAP;
      8'h08:
      begin
        cls = EXRN_CLS_ABORT;
        has_err = 1'b1;
      end
      // Machine check carries an error code in this design.
      8'h12:
      begin
        cls = EXRN_CLS_ABORT;
        has_err = 1'b1;
      end
      default: cls = EXRN_CLS_MASKABLE_INTERRUPT_PIN;
    endcase
  end
endmodule

// ===== verilog/exrn_unit.sv
// Exception classification and interrupt acceptance at retired instruction boundaries.
`timescale 1ns/100ps
module exrn_unit
  import exrn_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Retirement stream
  input wire logic retire_valid,
  input wire logic [exrn_pkg::EXRN_IP_W-1:0] retire_ip,
  input wire logic [exrn_pkg::EXRN_IP_W-1:0] retire_next_ip,
  input wire logic retire_rep_iter,
  input wire logic retire_interrupt_return_instruction,
  input wire logic retire_int3,
  input wire logic retire_into,
  input wire logic retire_intn,
  input wire logic [exrn_pkg::EXRN_VEC_W-1:0] retire_intn_vec,
  input wire logic retire_exc,
  input wire logic [exrn_pkg::EXRN_VEC_W-1:0] retire_exc_vec,
  input wire logic [exrn_pkg::EXRN_ERR_W-1:0] retire_exc_err,
  input wire logic retire_partial_state,
  input wire logic overflow_flag,
  input wire logic processor_flags_if,
  // Machine check
  input wire logic mchk_err,
  input wire logic [exrn_pkg::EXRN_ERR_W-1:0] mchk_code,
  // External interrupt sources
  input wire logic nmi_pin,
  input wire logic bus_msg_valid,
  input wire logic [2:0] bus_msg_mode,
  input wire logic maskable_interrupt_pin,
  input wire logic [exrn_pkg::EXRN_VEC_W-1:0] maskable_vec,
  // Dispatch to the sequencer
  output logic disp_valid,
  output logic [exrn_pkg::EXRN_VEC_W-1:0] disp_vec,
  output exrn_pkg::exrn_class_e disp_class,
  output logic [exrn_pkg::EXRN_IP_W-1:0] disp_ret_ip,
  output logic disp_push_err,
  output logic [exrn_pkg::EXRN_ERR_W-1:0] disp_err,
  output logic disp_rollback,
  output logic disp_restartable,
  output logic disp_src_maskable_interrupt_pin,
  output logic maskable_ack,
  output logic nmi_block
);
  import exrn_pkg::*;

  logic disp_valid_r, disp_valid_nxt;
  logic [EXRN_VEC_W-1:0] disp_vec_r, disp_vec_nxt;
  exrn_class_e disp_class_r, disp_class_nxt;
  logic [EXRN_IP_W-1:0] disp_ret_ip_r, disp_ret_ip_nxt;
  logic disp_push_err_r, disp_push_err_nxt;
  logic [EXRN_ERR_W-1:0] disp_err_r, disp_err_nxt;
  logic disp_rollback_r, disp_rollback_nxt;
  logic disp_restart_r, disp_restart_nxt;
  logic disp_src_maskable_interrupt_pin_r, disp_src_maskable_interrupt_pin_nxt;
  logic ack_r, ack_nxt;
  logic nmi_pend_r, nmi_pend_nxt;
  logic nmi_block_r, nmi_block_nxt;
  logic nmi_pin_d_r;
  logic mchk_pend_r, mchk_pend_nxt;
  logic [EXRN_ERR_W-1:0] mchk_code_r, mchk_code_nxt;

  exrn_class_e tbl_cls;
  logic tbl_err;
  logic [EXRN_VEC_W-1:0] exc_vec;
  logic exc_hit;
  logic nmi_event;

  // Exceptions from decode arrive tagged on the retiring instruction, so they can
  // never overtake older instructions in program order.
  always_comb
  begin
    exc_hit = 1'b0;
    exc_vec = EXRN_VEC_RST;
    if (retire_valid)
    begin
      if (retire_exc)
      begin
        exc_hit = 1'b1;
        exc_vec = retire_exc_vec;
      end
      else if (retire_int3)
      begin
        exc_hit = 1'b1;
        exc_vec = EXRN_VEC_BP;
      end
      else if (retire_into && overflow_flag)
      begin
        exc_hit = 1'b1;
        exc_vec = EXRN_VEC_OVF;
      end
    end
  end

  exrn_class_table u_table (
    .vec(exc_vec),
    .cls(tbl_cls),
    .has_err(tbl_err)
  );

  // Pin edge or NMI-mode bus message.
  assign nmi_event = (nmi_pin && !nmi_pin_d_r) ||
                     (bus_msg_valid && bus_msg_mode == EXRN_MODE_NMI);

  always_comb
  begin
    disp_valid_nxt = 1'b0;
    disp_vec_nxt = disp_vec_r;
    disp_class_nxt = disp_class_r;
    disp_ret_ip_nxt = disp_ret_ip_r;
    disp_push_err_nxt = 1'b0;
    disp_err_nxt = disp_err_r;
    disp_rollback_nxt = 1'b0;
    disp_restart_nxt = disp_restart_r;
    disp_src_maskable_interrupt_pin_nxt = 1'b0;
    ack_nxt = 1'b0;
    nmi_pend_nxt = nmi_pend_r || nmi_event;
    mchk_pend_nxt = mchk_pend_r || mchk_err;
    mchk_code_nxt = mchk_err ? mchk_code : mchk_code_r;
    nmi_block_nxt = nmi_block_r;
    // The return ends the handler; a new NMI in the same cycle still waits one boundary.
    if (retire_valid && retire_interrupt_return_instruction)
      nmi_block_nxt = 1'b0;
    if (mchk_pend_r)
    begin
      // Abort: imprecise, not restartable, code supplied.
      disp_valid_nxt = 1'b1;
      disp_vec_nxt = EXRN_VEC_MC;
      disp_class_nxt = EXRN_CLS_ABORT;
      disp_ret_ip_nxt = retire_ip;
      disp_push_err_nxt = 1'b1;
      disp_err_nxt = mchk_code_r;
      disp_restart_nxt = 1'b0;
      mchk_pend_nxt = mchk_err;
    end
    else if (exc_hit)
    begin
      disp_valid_nxt = 1'b1;
      disp_vec_nxt = exc_vec;
      disp_class_nxt = tbl_cls;
      disp_push_err_nxt = tbl_err;
      disp_err_nxt = retire_exc ? retire_exc_err : EXRN_ERR_ZERO;
      disp_restart_nxt = tbl_cls != EXRN_CLS_ABORT;
      if (tbl_cls == EXRN_CLS_FAULT)
      begin
        disp_ret_ip_nxt = retire_ip;
        disp_rollback_nxt = 1'b1;
        // Partially committed state is reported, not hidden.
        disp_restart_nxt = !retire_partial_state;
      end
      else
        disp_ret_ip_nxt = retire_next_ip;
    end
    else if (retire_valid && retire_intn)
    begin
      disp_valid_nxt = 1'b1;
      disp_vec_nxt = retire_intn_vec;
      disp_class_nxt = EXRN_CLS_MASKABLE_INTERRUPT_PIN;
      disp_ret_ip_nxt = retire_next_ip;
      disp_push_err_nxt = 1'b0;
      disp_restart_nxt = 1'b1;
      disp_src_maskable_interrupt_pin_nxt = 1'b1;
    end
    else if (retire_valid && !nmi_block_r && (nmi_pend_r || nmi_event))
    begin
      // Taken ignoring the enable flag, at the first retired boundary once blocking is clear.
      disp_valid_nxt = 1'b1;
      disp_vec_nxt = EXRN_VEC_NMI;
      disp_class_nxt = EXRN_CLS_MASKABLE_INTERRUPT_PIN;
      disp_ret_ip_nxt = retire_next_ip;
      disp_restart_nxt = 1'b1;
      disp_src_maskable_interrupt_pin_nxt = 1'b1;
      nmi_pend_nxt = 1'b0;
      nmi_block_nxt = 1'b1;
    end
    else if (retire_valid && !nmi_block_r && processor_flags_if && maskable_interrupt_pin)
    begin
      // A maskable vector two runs the handler but leaves blocking alone.
      disp_valid_nxt = 1'b1;
      disp_vec_nxt = maskable_vec;
      disp_class_nxt = EXRN_CLS_MASKABLE_INTERRUPT_PIN;
      disp_ret_ip_nxt = retire_next_ip;
      disp_restart_nxt = 1'b1;
      disp_src_maskable_interrupt_pin_nxt = 1'b1;
      ack_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      disp_valid_r <= 1'b0;
      disp_vec_r <= EXRN_VEC_RST;
      disp_class_r <= EXRN_CLS_MASKABLE_INTERRUPT_PIN;
      disp_ret_ip_r <= EXRN_IP_RST;
      disp_push_err_r <= 1'b0;
      disp_err_r <= EXRN_ERR_ZERO;
      disp_rollback_r <= 1'b0;
      disp_restart_r <= 1'b0;
      disp_src_maskable_interrupt_pin_r <= 1'b0;
      ack_r <= 1'b0;
      nmi_pend_r <= 1'b0;
      nmi_block_r <= 1'b0;
      nmi_pin_d_r <= 1'b0;
      mchk_pend_r <= 1'b0;
      mchk_code_r <= EXRN_ERR_ZERO;
    end
    else
    begin
      disp_valid_r <= disp_valid_nxt;
      disp_vec_r <= disp_vec_nxt;
      disp_class_r <= disp_class_nxt;
      disp_ret_ip_r <= disp_ret_ip_nxt;
      disp_push_err_r <= disp_push_err_nxt;
      disp_err_r <= disp_err_nxt;
      disp_rollback_r <= disp_rollback_nxt;
      disp_restart_r <= disp_restart_nxt;
      disp_src_maskable_interrupt_pin_r <= disp_src_maskable_interrupt_pin_nxt;
      ack_r <= ack_nxt;
      nmi_pend_r <= nmi_pend_nxt;
      nmi_block_r <= nmi_block_nxt;
      nmi_pin_d_r <= nmi_pin;
      mchk_pend_r <= mchk_pend_nxt;
      mchk_code_r <= mchk_code_nxt;
    end
  end

  assign disp_valid = disp_valid_r;
  assign disp_vec = disp_vec_r;
  assign disp_class = disp_class_r;
  assign disp_ret_ip = disp_ret_ip_r;
  assign disp_push_err = disp_push_err_r;
  assign disp_err = disp_err_r;
  assign disp_rollback = disp_rollback_r;
  assign disp_restartable = disp_restart_r;
  assign disp_src_maskable_interrupt_pin = disp_src_maskable_interrupt_pin_r;
  assign maskable_ack = ack_r;
  assign nmi_block = nmi_block_r;

  chk_intn_no_err:
  assert property (@(posedge clk_sys) disable iff (sys_rst)
    (retire_valid && retire_intn && !retire_exc && !retire_int3 && !retire_into && !mchk_pend_r)
    |=> disp_valid && !disp_push_err && disp_class == EXRN_CLS_MASKABLE_INTERRUPT_PIN)
  else $error("software interrupt pushed an error code");

  chk_bp_vector:
  assert property (@(posedge clk_sys) disable iff (sys_rst)
    (retire_valid && retire_int3 && !retire_exc && !mchk_pend_r)
    |=> disp_valid && disp_vec == EXRN_VEC_BP && disp_ret_ip == $past(retire_next_ip))
  else $error("breakpoint not raised");

  chk_mc_vector:
  assert property (@(posedge clk_sys) disable iff (sys_rst)
    (mchk_err && !mchk_pend_r) |=> ##1 disp_valid && disp_vec == EXRN_VEC_MC && disp_push_err)
  else $error("machine check not raised");

  chk_fault_ip:
  assert property (@(posedge clk_sys) disable iff (sys_rst)
    (disp_valid && disp_class == EXRN_CLS_FAULT) |-> disp_rollback && disp_ret_ip == $past(retire_ip))
  else $error("fault return pointer wrong");

  chk_nmi_block:
  assert property (@(posedge clk_sys) disable iff (sys_rst)
    (retire_valid && !nmi_block_r && (nmi_pend_r || nmi_event) && !mchk_pend_r && !exc_hit &&
     !retire_intn) |=> disp_valid && disp_vec == EXRN_VEC_NMI && nmi_block)
  else $error("nmi blocking not armed");

  chk_block_maskable_interrupt_pin:
  assert property (@(posedge clk_sys) disable iff (sys_rst)
    $past(nmi_block) && disp_valid && disp_src_maskable_interrupt_pin |-> !maskable_ack && $past(retire_intn))
  else $error("interrupt accepted while blocked");

  chk_mask_gate:
  assert property (@(posedge clk_sys) disable iff (sys_rst)
    (disp_valid && maskable_ack) |->
      $past(processor_flags_if) && !$past(nmi_block) && $past(maskable_interrupt_pin))
  else $error("maskable interrupt taken while refused");

  chk_mask_no_block:
  assert property (@(posedge clk_sys) disable iff (sys_rst)
    (disp_valid && maskable_ack) |-> !nmi_block && disp_vec == $past(maskable_vec))
  else $error("maskable interrupt armed nmi blocking");

  chk_interrupt_return_instruction_clear:
  assert property (@(posedge clk_sys) disable iff (sys_rst)
    (retire_valid && retire_interrupt_return_instruction && nmi_block) |=> !nmi_block)
  else $error("blocking not released by return");

  chk_maskable_interrupt_pin_boundary:
  assert property (@(posedge clk_sys) disable iff (sys_rst)
    (disp_valid && disp_src_maskable_interrupt_pin) |-> $past(retire_valid))
  else $error("interrupt taken off boundary");

  chk_trap_next_ip:
  assert property (@(posedge clk_sys) disable iff (sys_rst)
    (disp_valid && disp_class == EXRN_CLS_TRAP) |->
      !disp_rollback && disp_ret_ip == $past(retire_next_ip))
  else $error("trap return pointer wrong");

  chk_abort_final:
  assert property (@(posedge clk_sys) disable iff (sys_rst)
    (disp_valid && disp_class == EXRN_CLS_ABORT) |-> !disp_restartable && !disp_rollback)
  else $error("abort offered a restart");

  chk_fault_restart:
  assert property (@(posedge clk_sys) disable iff (sys_rst)
    (disp_valid && disp_class == EXRN_CLS_FAULT) |->
      disp_restartable == !$past(retire_partial_state))
  else $error("fault restart flag wrong");

  chk_rep_iter_ip:
  assert property (@(posedge clk_sys) disable iff (sys_rst)
    (retire_valid && retire_rep_iter) ##1 (disp_valid && disp_src_maskable_interrupt_pin) |->
      disp_ret_ip == $past(retire_next_ip))
  else $error("repeat iteration return pointer wrong");

  chk_ovf_trap:
  assert property (@(posedge clk_sys) disable iff (sys_rst)
    (retire_valid && retire_into && overflow_flag && !retire_exc && !retire_int3 && !mchk_pend_r)
    |=> disp_vec == EXRN_VEC_OVF && disp_class == EXRN_CLS_TRAP)
  else $error("overflow trap missing");
endmodule
